// ===== rtl/trig_seq_defs.svh
// Purpose: constants for the sequential trigger engine
// Assumes: one clock, mclk at 40 MHz
// Notes:
`ifndef TRIG_SEQ_DEFS_SVH
`define TRIG_SEQ_DEFS_SVH
`define TS_LEVELS      16
`define TS_DATA_W      48
`define TS_QUAL_W      8
`define TS_CQ_W        55
`define TS_DEPTH       1000
`define TS_CNT_W       14
`define TS_ADDR_W      10
// register byte offsets
`define TS_REG_CTRL    8'h00
`define TS_REG_STATUS  8'h04
`define TS_REG_PRE_TRIGGER_DEPTH 8'h08
`define TS_REG_SEL     8'h0C
`define TS_REG_PAT_LO  8'h10
`define TS_REG_PAT_HI  8'h14
`define TS_REG_MSK_LO  8'h18
`define TS_REG_MSK_HI  8'h1C
`define TS_REG_LVLCFG  8'h20
`define TS_REG_RDIDX   8'h24
`define TS_REG_RD_LO   8'h28
`define TS_REG_RD_HI   8'h2C
// ctrl bits
`define TS_CTRL_START  0
`define TS_CTRL_SAVE   1
`define TS_CTRL_RSEN   2
`define TS_CTRL_RSINV  3
`define TS_CTRL_CQ1EN  4
`define TS_CTRL_CQ2EN  5
`define TS_CTRL_AUXSEL 6
// pattern slot select: 0-15 levels, 16 restart, 17/18 clock qualifiers
`define TS_SEL_RESTART 5'd16
`define TS_SEL_CQ1     5'd17
`define TS_SEL_CQ2     5'd18
`endif

// ===== rtl/trig_seq_pkg.sv
// Purpose: types for the sequential trigger engine
// Assumes: nothing
// Notes: delay mode encodings follow the order of the menu choices
package trig_seq_pkg;
    typedef enum logic [2:0] {
        DLY_NONE, DLY_AFTER, DLY_NOT_ON, DLY_BEFORE, DLY_ON, COUNT_MATCHES_MODE
    } delay_mode_t;
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_POST, ST_DONE} cap_state_t;
endpackage

// ===== rtl/state_trigger_sequencer.sv
// Purpose: sequential trigger stack, restart, clock qualify, capture and save
// Assumes: probe inputs are asynchronous and pass two flops; avalon slave on mclk
// Notes: main memory is read at two addresses per cycle, bus read path and save copy; save copies one word per cycle
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "trig_seq_defs.svh"
module state_trigger_sequencer #(
    parameter int DEPTH  = `TS_DEPTH,
    parameter int LEVELS = `TS_LEVELS
) (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic [47:0] probe_data,
    input  wire logic [5:0]  probe_qualifier_bits,
    input  wire logic        ext_qual,
    input  wire logic        link_qual,
    input  wire logic        probe_clk_en,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             triggered,
    output logic             collect_done
);
    // =====================================================
    // input synchronisers
    logic [57:0] s1_q, s2_q;
    logic        sample_q;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= {probe_clk_en, link_qual, ext_qual, probe_qualifier_bits, probe_data, 1'b0};
            s2_q <= s1_q;
        end
    end
    // edge of the synchronised sample strobe marks one new word
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) sample_q <= 1'b0;
        else sample_q <= s2_q[57];
    end
    wire logic        smp_stb = s2_q[57] & ~sample_q;
    wire logic [47:0] smp_data = s2_q[48:1];
    wire logic [7:0]  smp_qual = s2_q[56:49];
    wire logic [54:0] smp_cq = {smp_qual[6:0], smp_data};

    // =====================================================
    // configuration storage
    logic [55:0] lvl_pat_q [LEVELS];
    logic [55:0] lvl_msk_q [LEVELS];
    logic        lvl_inv_q [LEVELS];
    trig_seq_pkg::delay_mode_t lvl_mode_q [LEVELS];
    logic [13:0] lvl_cnt_q [LEVELS];
    logic [3:0]  last_lvl_q;
    logic [55:0] rs_pat_q, rs_msk_q;
    logic [54:0] cq_pat_q [2];
    logic [54:0] cq_msk_q [2];
    logic [6:0]  ctrl_q;
    logic [9:0]  pre_trigger_depth_q;
    logic [4:0]  sel_q;
    logic [9:0]  rdidx_q;
    logic [63:0] pat_wr_q;
    logic [63:0] msk_wr_q;
    logic        start_p_q, save_p_q;

    wire logic wr = avs_write & ~avs_waitrequest;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q    <= '0;
            pre_trigger_depth_q <= '0;
            sel_q     <= '0;
            rdidx_q   <= '0;
            pat_wr_q  <= '0;
            msk_wr_q  <= '0;
            start_p_q <= 1'b0;
            save_p_q  <= 1'b0;
            last_lvl_q <= '0;
        end else begin
            start_p_q <= wr && avs_address == `TS_REG_CTRL && avs_writedata[`TS_CTRL_START];
            save_p_q  <= wr && avs_address == `TS_REG_CTRL && avs_writedata[`TS_CTRL_SAVE];
            if (wr) begin
                case (avs_address)
                    `TS_REG_CTRL:    ctrl_q <= {avs_writedata[6:2], 2'b00};
                    `TS_REG_PRE_TRIGGER_DEPTH: pre_trigger_depth_q <= avs_writedata[9:0];
                    `TS_REG_SEL:     sel_q <= avs_writedata[4:0];
                    `TS_REG_PAT_LO:  pat_wr_q[31:0] <= avs_writedata;
                    `TS_REG_PAT_HI:  pat_wr_q[63:32] <= avs_writedata;
                    `TS_REG_MSK_LO:  msk_wr_q[31:0] <= avs_writedata;
                    `TS_REG_MSK_HI:  msk_wr_q[63:32] <= avs_writedata;
                    `TS_REG_LVLCFG:  if (sel_q == 5'd0) last_lvl_q <= avs_writedata[23:20];
                    `TS_REG_RDIDX:   rdidx_q <= avs_writedata[9:0];
                    default: ;
                endcase
            end
        end
    end

    // msk bit 1 = compare that bit; writing MSK_HI commits the slot
    wire logic commit = wr && avs_address == `TS_REG_MSK_HI;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < LEVELS; i++) begin
                lvl_pat_q[i]  <= '0;
                lvl_msk_q[i]  <= '0;
                lvl_inv_q[i]  <= 1'b0;
                lvl_mode_q[i] <= trig_seq_pkg::DLY_NONE;
                lvl_cnt_q[i]  <= '0;
            end
            rs_pat_q <= '0;
            rs_msk_q <= '0;
            cq_pat_q[0] <= '0;
            cq_pat_q[1] <= '0;
            cq_msk_q[0] <= '0;
            cq_msk_q[1] <= '0;
        end else if (commit) begin
            if (sel_q < 5'd16) begin
                lvl_pat_q[sel_q[3:0]] <= pat_wr_q[55:0];
                lvl_msk_q[sel_q[3:0]] <= {avs_writedata[23:0], msk_wr_q[31:0]};
            end else if (sel_q == `TS_SEL_RESTART) begin
                rs_pat_q <= pat_wr_q[55:0];
                rs_msk_q <= {avs_writedata[23:0], msk_wr_q[31:0]};
            end else if (sel_q == `TS_SEL_CQ1 || sel_q == `TS_SEL_CQ2) begin
                // external bit cannot demand zero: pattern forced to one
                cq_pat_q[sel_q[0] ? 0 : 1] <= {1'b1, pat_wr_q[53:0]};
                cq_msk_q[sel_q[0] ? 0 : 1] <= {avs_writedata[22:0], msk_wr_q[31:0]};
            end
        end else if (wr && avs_address == `TS_REG_LVLCFG && sel_q < 5'd16) begin
            lvl_inv_q[sel_q[3:0]] <= avs_writedata[19];
            // level zero keeps no delay qualifier
            lvl_mode_q[sel_q[3:0]] <= (sel_q == 5'd0) ? trig_seq_pkg::DLY_NONE
                : trig_seq_pkg::delay_mode_t'(avs_writedata[18:16]);
            lvl_cnt_q[sel_q[3:0]] <= (sel_q == 5'd0) ? 14'h0000 : avs_writedata[13:0];
        end
    end

    // =====================================================
    // qualification, restart and level compare
    wire logic cq_hit = (ctrl_q[`TS_CTRL_CQ1EN] && ((smp_cq ^ cq_pat_q[0]) & cq_msk_q[0]) == '0)
                     || (ctrl_q[`TS_CTRL_CQ2EN] && ((smp_cq ^ cq_pat_q[1]) & cq_msk_q[1]) == '0);
    wire logic qualified = smp_stb &&
        (cq_hit || !(ctrl_q[`TS_CTRL_CQ1EN] || ctrl_q[`TS_CTRL_CQ2EN]));
    wire logic [55:0] smp_word = {smp_qual, smp_data};
    wire logic rs_match = ((smp_word ^ rs_pat_q) & rs_msk_q) == '0;
    wire logic restart = qualified && ctrl_q[`TS_CTRL_RSEN]
                      && (rs_match ^ ctrl_q[`TS_CTRL_RSINV]);

    logic [3:0]  lvl_q;
    logic [13:0] dcnt_q;
    wire logic raw_hit = ((smp_word ^ lvl_pat_q[lvl_q]) & lvl_msk_q[lvl_q]) == '0;
    wire logic lvl_hit = raw_hit ^ lvl_inv_q[lvl_q];
    wire logic [13:0] n_cnt = lvl_cnt_q[lvl_q];
    logic adv;
    always_comb begin
        adv = 1'b0;
        case (lvl_mode_q[lvl_q])
            trig_seq_pkg::DLY_NONE:   adv = lvl_hit;
            trig_seq_pkg::DLY_AFTER:  adv = lvl_hit && dcnt_q >= n_cnt;
            trig_seq_pkg::DLY_NOT_ON: adv = lvl_hit && dcnt_q != n_cnt;
            trig_seq_pkg::DLY_BEFORE: adv = lvl_hit && dcnt_q < n_cnt;
            trig_seq_pkg::DLY_ON:     adv = lvl_hit && dcnt_q == n_cnt;
            trig_seq_pkg::COUNT_MATCHES_MODE: adv = lvl_hit && dcnt_q + 14'd1 >= n_cnt;
            default: adv = 1'b0;
        endcase
    end

    // =====================================================
    // capture state and sequencer
    trig_seq_pkg::cap_state_t st_q;
    logic [9:0] wptr_q, trig_ptr_q, stored_q, post_q;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lvl_q  <= '0;
            dcnt_q <= '0;
        end else if (start_p_q) begin
            lvl_q  <= '0;
            dcnt_q <= '0;
        end else if (st_q == trig_seq_pkg::ST_ARMED && qualified) begin
            if (restart) begin
                lvl_q  <= '0;
                dcnt_q <= '0;
            end else if (adv && lvl_q != last_lvl_q) begin
                lvl_q  <= lvl_q + 4'd1;
                dcnt_q <= '0;
            end else if (lvl_mode_q[lvl_q] != trig_seq_pkg::COUNT_MATCHES_MODE || lvl_hit) begin
                if (dcnt_q != 14'h3FFF) dcnt_q <= dcnt_q + 14'd1;
            end
        end
    end

    wire logic fire = st_q == trig_seq_pkg::ST_ARMED && qualified && !restart
                   && adv && lvl_q == last_lvl_q;
    wire logic [9:0] post_need = 10'(DEPTH - 1) - ((stored_q < pre_trigger_depth_q) ? stored_q : pre_trigger_depth_q);
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_q       <= trig_seq_pkg::ST_IDLE;
            wptr_q     <= '0;
            trig_ptr_q <= '0;
            stored_q   <= '0;
            post_q     <= '0;
        end else if (start_p_q) begin
            st_q     <= trig_seq_pkg::ST_ARMED;
            wptr_q   <= '0;
            stored_q <= '0;
        end else begin
            case (st_q)
                trig_seq_pkg::ST_ARMED: if (qualified) begin
                    wptr_q <= (wptr_q == 10'(DEPTH - 1)) ? 10'h000 : wptr_q + 10'h001;
                    if (stored_q != 10'(DEPTH)) stored_q <= stored_q + 10'h001;
                    if (fire) begin
                        trig_ptr_q <= wptr_q;
                        post_q     <= post_need;
                        st_q       <= (post_need == 10'h000) ? trig_seq_pkg::ST_DONE
                                                             : trig_seq_pkg::ST_POST;
                    end
                end
                trig_seq_pkg::ST_POST: if (qualified) begin
                    wptr_q <= (wptr_q == 10'(DEPTH - 1)) ? 10'h000 : wptr_q + 10'h001;
                    // keep counting so the read index can find the oldest word after a wrap
                    if (stored_q != 10'(DEPTH)) stored_q <= stored_q + 10'h001;
                    post_q <= post_q - 10'h001;
                    if (post_q == 10'h001) st_q <= trig_seq_pkg::ST_DONE;
                end
                trig_seq_pkg::ST_IDLE, trig_seq_pkg::ST_DONE: ;
                default: st_q <= trig_seq_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            triggered    <= 1'b0;
            collect_done <= 1'b0;
        end else begin
            triggered    <= st_q == trig_seq_pkg::ST_POST || st_q == trig_seq_pkg::ST_DONE;
            collect_done <= st_q == trig_seq_pkg::ST_DONE;
        end
    end

    // =====================================================
    // main and auxiliary memories, save copy
    logic [55:0] main_mem [DEPTH];
    logic [55:0] aux_mem  [DEPTH];
    logic [9:0]  cp_q;
    logic        copying_q;
    always_ff @(posedge mclk) begin
        if ((st_q == trig_seq_pkg::ST_ARMED || st_q == trig_seq_pkg::ST_POST) && qualified)
            main_mem[wptr_q] <= smp_word;
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            copying_q <= 1'b0;
            cp_q      <= '0;
        end else if (save_p_q) begin
            copying_q <= 1'b1;
            cp_q      <= '0;
        end else if (copying_q) begin
            cp_q <= cp_q + 10'h001;
            if (cp_q == 10'(DEPTH - 1)) copying_q <= 1'b0;
        end
    end
    always_ff @(posedge mclk) begin
        if (copying_q) aux_mem[cp_q] <= main_mem[cp_q];
    end

    // =====================================================
    // avalon read path: one wait cycle per access
    logic       wait_q;
    // rdidx counts from the oldest stored word
    wire logic [10:0] base = (stored_q < 10'(DEPTH)) ? 11'h000 : {1'b0, wptr_q};
    wire logic [10:0] sum  = base + {1'b0, rdidx_q};
    wire logic [9:0]  ridx = (sum >= 11'(DEPTH)) ? 10'(sum - 11'(DEPTH)) : sum[9:0];
    wire logic [55:0] rword = ctrl_q[`TS_CTRL_AUXSEL - 2 + 2] ? aux_mem[ridx] : main_mem[ridx];
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wait_q       <= 1'b1;
            avs_readdata <= '0;
        end else begin
            wait_q <= !(avs_read || avs_write) || !wait_q;
            if (avs_read && wait_q) begin
                case (avs_address)
                    `TS_REG_CTRL:    avs_readdata <= {25'h0, ctrl_q};
                    `TS_REG_STATUS:  avs_readdata <= {copying_q, 3'h0, lvl_q, 10'h0, trig_ptr_q,
                                                      2'h0, st_q};
                    `TS_REG_PRE_TRIGGER_DEPTH: avs_readdata <= {22'h0, pre_trigger_depth_q};
                    `TS_REG_SEL:     avs_readdata <= {27'h0, sel_q};
                    `TS_REG_RDIDX:   avs_readdata <= {12'h0, stored_q, rdidx_q};
                    `TS_REG_RD_LO:   avs_readdata <= rword[31:0];
                    `TS_REG_RD_HI:   avs_readdata <= {8'h00, rword[55:32]};
                    default:         avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign avs_waitrequest = wait_q;

    // =====================================================
    // checks
    restart_level_a: assert property (@(posedge mclk) disable iff (!reset_n)
        st_q == trig_seq_pkg::ST_ARMED && restart && !start_p_q |=> lvl_q == 4'h0)
        else $error("restart did not return to level zero");
    // level 15 excluded: a lowered last level may let it wrap
    restart_off_a: assert property (@(posedge mclk) disable iff (!reset_n)
        !ctrl_q[`TS_CTRL_RSEN] && !start_p_q && lvl_q != 4'h0 && lvl_q != 4'hF |=> lvl_q != 4'h0)
        else $error("restart active while disabled");
    level_step_a: assert property (@(posedge mclk) disable iff (!reset_n)
        lvl_q != $past(lvl_q) && lvl_q != 4'h0 |-> lvl_q == $past(lvl_q) + 4'd1)
        else $error("level skipped");
    done_flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
        st_q == trig_seq_pkg::ST_DONE && !start_p_q |=> ##1 collect_done)
        else $error("done not flagged");
    zero_delay_a: assert property (@(posedge mclk) disable iff (!reset_n)
        st_q == trig_seq_pkg::ST_ARMED && qualified && !restart && !start_p_q
        && lvl_q == 4'h0 && lvl_hit && last_lvl_q != 4'h0 |=> lvl_q == 4'h1)
        else $error("level zero has a delay");
    unqual_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
        !qualified && !start_p_q |=> $stable(wptr_q))
        else $error("unqualified sample stored");
    save_copy_a: assert property (@(posedge mclk) disable iff (!reset_n)
        save_p_q |=> copying_q [*8])
        else $error("save copy did not run");
    fire_trig_a: assert property (@(posedge mclk) disable iff (!reset_n)
        fire && !start_p_q |=> st_q != trig_seq_pkg::ST_ARMED ##1 triggered)
        else $error("trigger not declared");
endmodule
`default_nettype wire

// ===== testbench/probe_source.sv
// Purpose: model of the probed circuit, presents one sampled word per request
// Assumes: send is raised for one cycle while busy is low
// Notes: the word shows on the probes, then a strobe mid-frame, then an inverted word
`timescale 1ns/10ps
`default_nettype none
module probe_source (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic [55:0] word,
    input  wire logic        send,
    output logic             busy,
    output logic [47:0]      probe_data,
    output logic [5:0]       probe_qualifier_bits,
    output logic             ext_qual,
    output logic             link_qual,
    output logic             probe_clk_en
);
    logic [3:0]  phase_q;
    logic [55:0] word_q;
    // ==========================================================
    // frame sequencing
    assign busy = send | (phase_q != 4'h0);
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= 4'h0;
            word_q  <= 56'h0;
        end else if (phase_q == 4'hC) begin
            phase_q <= 4'h0;
            // hold time over: stale data must not pass for a valid word
            word_q  <= ~word_q;
        end else if (phase_q != 4'h0) begin
            phase_q <= phase_q + 4'h1;
        end else if (send) begin
            phase_q <= 4'h1;
            word_q  <= word;
        end
    end
    assign {link_qual, ext_qual, probe_qualifier_bits, probe_data} = word_q;
    // strobe well inside the frame so the data is settled on both sides
    assign probe_clk_en = (phase_q >= 4'h4) && (phase_q <= 4'h7);
endmodule
`default_nettype wire

// ===== testbench/tb_state_trigger_sequencer.sv
// Purpose: self-checking bench for the sequential trigger engine
// Assumes: one wait state on every register access
// Notes: probe words come from probe_source, registers over avalon
`timescale 1ns/10ps
`default_nettype none
`include "trig_seq_defs.svh"
module tb_state_trigger_sequencer;
    logic        mclk, reset_n, avs_read, avs_write, avs_waitrequest;
    logic        triggered, collect_done, ext_qual, link_qual, probe_clk_en;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd, last_lo;
    logic [47:0] probe_data;
    logic [5:0]  probe_qualifier_bits;
    logic [55:0] src_word;
    logic        src_send, src_busy;
    int          n_errors, cmp_count, n;
    localparam logic [55:0] full_msk = 56'hFF_FFFF_FFFF_FFFF;
    localparam logic [55:0] data_msk = 56'h00_FFFF_FFFF_FFFF;
    localparam logic [55:0] w_a = 56'h00_1111_2222_3333;
    localparam logic [55:0] w_b = 56'h00_4444_5555_6666;
    localparam logic [55:0] w_c = 56'h00_7777_8888_9999;
    localparam logic [55:0] w_r = 56'h00_AAAA_BBBB_CCCC;

    state_trigger_sequencer uut (.mclk(mclk), .reset_n(reset_n), .probe_data(probe_data),
        .probe_qualifier_bits(probe_qualifier_bits), .ext_qual(ext_qual), .link_qual(link_qual),
        .probe_clk_en(probe_clk_en), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .triggered(triggered), .collect_done(collect_done));
    probe_source src (.mclk(mclk), .reset_n(reset_n), .word(src_word), .send(src_send),
        .busy(src_busy), .probe_data(probe_data), .probe_qualifier_bits(probe_qualifier_bits),
        .ext_qual(ext_qual), .link_qual(link_qual), .probe_clk_en(probe_clk_en));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ==========================================================
    // reporting
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic fail(input string msg);
        n_errors++;
        $display("BAD %0t %s", $time, msg);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) fail(msg);
    endtask

    // ==========================================================
    // bus and probe access
    task automatic acc(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr_en;
        avs_read      <= !wr_en;
        for (k = 0; k < 50; k++) begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (k == 50) begin
            fail("bus never answered");
            conclude();
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic rdr(input logic [7:0] a);
        acc(1'b0, a, 32'h0);
    endtask
    task automatic slot(input logic [4:0] s, input logic [55:0] p, input logic [55:0] m,
                        input logic [31:0] cfg);
        wr(`TS_REG_SEL, {27'h0, s});
        wr(`TS_REG_PAT_LO, p[31:0]);
        wr(`TS_REG_PAT_HI, {8'h00, p[55:32]});
        wr(`TS_REG_MSK_LO, m[31:0]);
        wr(`TS_REG_MSK_HI, {8'h00, m[55:32]});
        if (s < 5'd16) wr(`TS_REG_LVLCFG, cfg);
    endtask
    task automatic send(input logic [55:0] w);
        int k;
        @(posedge mclk);
        src_word <= w;
        src_send <= 1'b1;
        @(posedge mclk);
        src_send <= 1'b0;
        for (k = 0; k < 40 && src_busy === 1'b1; k++) @(posedge mclk);
        if (k == 40) begin
            fail("probe frame stuck");
            conclude();
        end
    endtask
    task automatic lvl(input logic [3:0] e);
        rdr(`TS_REG_STATUS);
        check({28'h0, rd[27:24]}, {28'h0, e}, "stack level");
    endtask
    task automatic trg(input logic e);
        check({31'h0, triggered}, {31'h0, e}, "trigger flag");
    endtask

    initial begin
        repeat (100000) @(posedge mclk);
        fail("run timed out");
        conclude();
    end

    // ==========================================================
    // main sequence
    initial begin
        reset_n = 1'b0; avs_address = 8'h00; avs_read = 1'b0; avs_write = 1'b0;
        avs_writedata = 32'h0; src_word = 56'h0; src_send = 1'b0;
        n_errors = 0; cmp_count = 0; rd = 32'h0; last_lo = 32'h0;
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        trg(1'b0);
        check({31'h0, collect_done}, 32'h0, "done after reset");
        rdr(`TS_REG_STATUS);
        check({30'h0, rd[1:0]}, 32'h0, "idle after reset");
        rdr(8'hFC);
        check(rd, 32'h0, "unmapped read");
        $display("test reset done");
        // two levels, occurrence count of three on level one
        slot(5'd0, w_a, full_msk, 32'h0010_0000);
        slot(5'd1, w_b, full_msk, 32'h0005_0003);
        wr(`TS_REG_PRE_TRIGGER_DEPTH, 32'h0);
        wr(`TS_REG_CTRL, 32'h1);
        send(w_b);
        lvl(4'h0);
        send(w_a);
        lvl(4'h1);
        send(w_b); send(w_c); send(w_b);
        trg(1'b0);
        send(w_b);
        trg(1'b1);
        for (n = 0; n < 1100 && collect_done !== 1'b1; n++) begin
            last_lo = 32'hC000_0000 + n;
            send({24'h0, last_lo});
        end
        check({31'h0, collect_done}, 32'h1, "memory never full");
        check({31'h0, n <= 1000}, 32'h1, "too many words stored");
        $display("test collect done");
        // save copies main into aux; newest word compared in both
        wr(`TS_REG_CTRL, 32'h2);
        for (n = 0; n < 700; n++) begin
            rdr(`TS_REG_STATUS);
            if (rd[31] === 1'b0) break;
        end
        check({31'h0, rd[31]}, 32'h0, "copy never ended");
        wr(`TS_REG_CTRL, 32'h40);
        wr(`TS_REG_RDIDX, 32'd999);
        rdr(`TS_REG_RD_LO);
        check(rd, last_lo, "aux newest word");
        wr(`TS_REG_CTRL, 32'h0);
        rdr(`TS_REG_RD_LO);
        check(rd, last_lo, "main newest word");
        $display("test save done");
        // restart off, then normal polarity
        slot(5'd0, w_a, full_msk, 32'h0020_0000);
        slot(5'd1, w_b, full_msk, 32'h0);
        slot(5'd16, w_r, full_msk, 32'h0);
        wr(`TS_REG_CTRL, 32'h1);
        send(w_a); send(w_r);
        lvl(4'h1);
        wr(`TS_REG_CTRL, 32'h5);
        send(w_a); send(w_r);
        lvl(4'h0);
        // inverted polarity: only the restart word avoids a return
        slot(5'd0, w_r, full_msk, 32'h0020_0000);
        wr(`TS_REG_CTRL, 32'hD);
        send(w_r);
        lvl(4'h1);
        send(w_b);
        lvl(4'h0);
        // restart of all don't-care blocks a single-level trigger
        slot(5'd16, w_r, 56'h0, 32'h0);
        slot(5'd0, w_a, full_msk, 32'h0);
        wr(`TS_REG_CTRL, 32'h5);
        send(w_a);
        trg(1'b0);
        $display("test restart done");
        // inverted level zero
        slot(5'd0, w_a, full_msk, 32'h0018_0000);
        wr(`TS_REG_CTRL, 32'h1);
        send(w_a);
        lvl(4'h0);
        send(w_c);
        lvl(4'h1);
        send(w_b);
        trg(1'b1);
        // clock qualifier on probe qualifier bit zero
        slot(5'd0, w_a, data_msk, 32'h0);
        slot(5'd17, 56'h01_0000_0000_0000, 56'h01_0000_0000_0000, 32'h0);
        wr(`TS_REG_CTRL, 32'h11);
        send(w_a);
        trg(1'b0);
        send(w_a | 56'h01_0000_0000_0000);
        trg(1'b1);
        $display("test qualifier done");
        // delay modes: on clock two, then not on clock zero
        slot(5'd0, w_a, full_msk, 32'h0010_0000);
        slot(5'd1, w_b, full_msk, 32'h0004_0002);
        wr(`TS_REG_CTRL, 32'h1);
        send(w_a); send(w_b); send(w_b);
        trg(1'b0);
        send(w_b);
        trg(1'b1);
        slot(5'd1, w_b, full_msk, 32'h0002_0000);
        wr(`TS_REG_CTRL, 32'h1);
        send(w_a); send(w_b);
        trg(1'b0);
        send(w_b);
        trg(1'b1);
        $display("test delay done");
        conclude();
    end
endmodule
`default_nettype wire
